// ==== hw/mmtw_core.sv ====
// mmtw_core: memory map on the core clock, served by toggle handshake
// assumes request fields stay stable from a toggle until its answer
`timescale 1ns/1ps
module mmtw_core (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // request from the link domain
  input wire logic reqTgl,
  input wire logic reqWe,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  // answer to the link domain
  output logic ackTgl,
  output logic [7:0] rdData,
  // written bytes toward the buffer
  output logic pushValid,
  input wire logic pushReady,
  output logic [15:0] pushData
);
  typedef struct packed {
    logic [1:0] reqSync;
    logic reqP;
    logic busy;
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
    logic ackTgl;
    logic [7:0] rdData;
  } mmtw_core_s;

  mmtw_core_s q, d;
  logic [7:0] mem [256];
  logic memWe;

  assign ackTgl = q.ackTgl;
  assign rdData = q.rdData;
  assign pushData = {q.addr, q.data};
  // the revision byte is read-only; writes to it are taken and dropped
  assign pushValid = q.busy & q.we & (q.addr != mmtw_pkg::REV_ADDR);
  assign memWe = pushValid & pushReady;

  always_comb
  begin
    d = q;
    d.reqSync = {q.reqSync[0], reqTgl};
    d.reqP = q.reqSync[1];
    if (q.reqSync[1] ^ q.reqP)
    begin
      d.busy = 1'b1;
      d.we = reqWe;
      d.addr = reqAddr;
      d.data = reqData;
    end
    else if (q.busy && !q.we)
    begin
      d.rdData = (q.addr == mmtw_pkg::REV_ADDR) ? mmtw_pkg::MAP_REV : mem[q.addr];
      d.ackTgl = ~q.ackTgl;
      d.busy = 1'b0;
    end
    else if (q.busy && (memWe || !pushValid))
    begin
      d.ackTgl = ~q.ackTgl;
      d.busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 256; i++)
        mem[i] <= 8'h00;
    end
    else if (memWe)
      mem[q.addr] <= q.data;
  end

  AST_REV_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (q.busy && !q.we && q.addr == mmtw_pkg::REV_ADDR && !(q.reqSync[1] ^ q.reqP))
    |=> q.rdData == mmtw_pkg::MAP_REV && q.ackTgl != $past(q.ackTgl))
    else $error("revision byte not returned");

  AST_WRITE_STALL: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pushValid && !pushReady && !(q.reqSync[1] ^ q.reqP)) |=> q.busy)
    else $error("write answered while buffer full");
endmodule

// ==== hw/mmtw_fifo.sv ====
// mmtw_fifo: single-clock first-word-first-out buffer
// assumes both sides on one clock; ready and valid may be combinational
`timescale 1ns/1ps
module mmtw_fifo #(
  parameter int WIDTH = mmtw_pkg::FIFO_WIDTH,
  parameter int DEPTH = mmtw_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_check
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } mmtw_fifo_s;

  mmtw_fifo_s q, d;
  logic push, pop;

  assign inReady = q.cnt != FULL;
  assign outValid = q.cnt != '0;
  assign outData = q.mem[q.rp];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = inData;
      d.wp = q.wp + 1'b1;
    end
    if (pop)
      d.rp = q.rp + 1'b1;
    if (push && !pop)
      d.cnt = q.cnt + 1'b1;
    else if (pop && !push)
      d.cnt = q.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cnt == FULL && !pop) |=> q.cnt == FULL && !inReady)
    else $error("fifo count passed its depth");
endmodule

// ==== hw/mmtw_pkg.sv ====
// constants, types and helpers shared by the two-wire management slave
// assumes a 100 MHz core clock and a separate link sampling clock
// Summary of operation
// - answer only at address 1010000, lsb read
// - select defaults to deselected high
// - deselected module ignores new starts and addresses
// - clock stretch never beyond 500 us
// - byte 128 shows memory map revision
// - ack address only when matched and selected
// - byte counter advances, wraps inside page
// - repeated start aborts write, counter kept
// - reads continue while host acknowledges
package mmtw_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [7:0] REV_ADDR = 8'h80;
  // arbitrary revision value, replace per product
  localparam logic [7:0] MAP_REV = 8'h01;
  localparam logic [6:0] PAGE_STEP = 7'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int STRETCH_MAX_NS = 500000;
  localparam int LINK_PERIOD_PS = 6000;
  localparam int STRETCH_CYCLES = STRETCH_MAX_NS * 1000 / LINK_PERIOD_PS;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 16;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WDATA,
    S_WWAIT,
    S_WACK,
    S_RWAIT,
    S_RDATA
  } mmtw_state_e;

  // counter advance that stays inside the current 128-byte page
  function automatic logic [7:0] nextAddr(input logic [7:0] a);
    return {a[7], a[6:0] + PAGE_STEP};
  endfunction
endpackage

// ==== hw/mmtw_slave.sv ====
// mmtw_slave: two-wire management slave, bit engine on the link clock
// assumes open-drain pins resolved outside; memory map on ref_clk
`timescale 1ns/1ps
module mmtw_slave #(
  parameter int STRETCH_CYCLES = mmtw_pkg::STRETCH_CYCLES
) (
  // core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // link sampling clock
  input wire logic linkClk,
  // two-wire pins
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic module_select_n,
  // written bytes, address in the high byte
  output logic wrValid,
  input wire logic wrReady,
  output logic [15:0] wrData
);
  localparam int CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] STRETCH_LAST = CW'(STRETCH_CYCLES - 1);

  if (STRETCH_CYCLES < 2)
  begin : g_check
    $error("stretch limit must be at least two cycles");
  end

  typedef struct packed {
    mmtw_pkg::mmtw_state_e st;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [7:0] addr;
    logic rw;
    logic firstByte;
    logic cont;
    logic sdaOe;
    logic sclOe;
    logic reqTgl;
    logic reqWe;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic [CW-1:0] stretchCnt;
    logic [1:0] sclSync;
    logic sclP;
    logic [1:0] sdaSync;
    logic sdaP;
    logic [1:0] selSync;
    logic [1:0] ackSync;
    logic ackP;
  } mmtw_link_s;

  mmtw_link_s q, d;
  logic coreAck;
  logic [7:0] coreRd;
  logic pushValid, pushReady;
  logic [15:0] pushData;
  logic sclHigh, sclRise, sclFall;
  logic start, stop, selected, ackEdge, timeout;

  // the device never drives a high level, it only pulls low
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe = q.sclOe;
  assign sdaOe = q.sdaOe;

  assign sclHigh = q.sclSync[1] & q.sclP;
  assign sclRise = q.sclSync[1] & ~q.sclP;
  assign sclFall = ~q.sclSync[1] & q.sclP;
  assign start = sclHigh & q.sdaP & ~q.sdaSync[1];
  assign stop = sclHigh & ~q.sdaP & q.sdaSync[1];
  assign selected = ~q.selSync[1];
  assign ackEdge = q.ackSync[1] ^ q.ackP;
  assign timeout = q.sclOe && (q.stretchCnt == STRETCH_LAST);

  always_comb
  begin
    d = q;
    d.sclSync = {q.sclSync[0], sclIn};
    d.sclP = q.sclSync[1];
    d.sdaSync = {q.sdaSync[0], sdaIn};
    d.sdaP = q.sdaSync[1];
    d.selSync = {q.selSync[0], module_select_n};
    d.ackSync = {q.ackSync[0], coreAck};
    d.ackP = q.ackSync[1];
    d.stretchCnt = q.sclOe ? q.stretchCnt + 1'b1 : '0;
    case (q.st)
      mmtw_pkg::S_IDLE:
      begin
        d.sdaOe = 1'b0;
        d.sclOe = 1'b0;
      end
      mmtw_pkg::S_ADDR:
      begin
        if (sclRise)
        begin
          d.shift = {q.shift[6:0], q.sdaSync[1]};
          d.bitCnt = q.bitCnt + 1'b1;
        end
        else if (sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS)
        begin
          d.bitCnt = '0;
          if (q.shift[7:1] == mmtw_pkg::DEV_ADDR && selected)
          begin
            d.sdaOe = 1'b1;
            d.rw = q.shift[0];
            d.st = mmtw_pkg::S_ADDR_ACK;
          end
          else
            d.st = mmtw_pkg::S_IDLE;
        end
      end
      mmtw_pkg::S_ADDR_ACK:
      begin
        if (sclFall)
        begin
          d.sdaOe = 1'b0;
          if (q.rw)
          begin
            // hold the clock low until the core has fetched the byte
            d.reqTgl = ~q.reqTgl;
            d.reqWe = 1'b0;
            d.reqAddr = q.addr;
            d.sclOe = 1'b1;
            d.st = mmtw_pkg::S_RWAIT;
          end
          else
          begin
            d.firstByte = 1'b1;
            d.st = mmtw_pkg::S_WDATA;
          end
        end
      end
      mmtw_pkg::S_WDATA:
      begin
        if (sclRise)
        begin
          d.shift = {q.shift[6:0], q.sdaSync[1]};
          d.bitCnt = q.bitCnt + 1'b1;
        end
        else if (sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS)
        begin
          d.bitCnt = '0;
          d.sdaOe = 1'b1;
          if (q.firstByte)
          begin
            // byte address only loads the counter, nothing is stored
            d.addr = q.shift;
            d.firstByte = 1'b0;
            d.st = mmtw_pkg::S_WACK;
          end
          else
          begin
            d.reqTgl = ~q.reqTgl;
            d.reqWe = 1'b1;
            d.reqAddr = q.addr;
            d.reqData = q.shift;
            d.sclOe = 1'b1;
            d.st = mmtw_pkg::S_WWAIT;
          end
        end
      end
      mmtw_pkg::S_WWAIT:
      begin
        if (ackEdge)
        begin
          d.sclOe = 1'b0;
          d.addr = mmtw_pkg::nextAddr(q.addr);
          d.st = mmtw_pkg::S_WACK;
        end
      end
      mmtw_pkg::S_WACK:
      begin
        if (sclFall)
        begin
          d.sdaOe = 1'b0;
          d.st = mmtw_pkg::S_WDATA;
        end
      end
      mmtw_pkg::S_RWAIT:
      begin
        if (ackEdge)
        begin
          d.shift = coreRd;
          d.sdaOe = ~coreRd[7];
          d.bitCnt = '0;
          d.sclOe = 1'b0;
          d.addr = mmtw_pkg::nextAddr(q.addr);
          d.st = mmtw_pkg::S_RDATA;
        end
      end
      mmtw_pkg::S_RDATA:
      begin
        if (sclRise && q.bitCnt == mmtw_pkg::BYTE_BITS)
          d.cont = ~q.sdaSync[1];
        else if (sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS)
        begin
          if (q.cont)
          begin
            d.reqTgl = ~q.reqTgl;
            d.reqWe = 1'b0;
            d.reqAddr = q.addr;
            d.sclOe = 1'b1;
            d.st = mmtw_pkg::S_RWAIT;
          end
          else
            d.st = mmtw_pkg::S_IDLE;
        end
        else if (sclFall)
        begin
          d.bitCnt = q.bitCnt + 1'b1;
          // after the last data bit the line is freed for the host answer
          d.sdaOe = (q.bitCnt == mmtw_pkg::LAST_BIT) ? 1'b0 : ~q.shift[6];
          d.shift = {q.shift[6:0], 1'b0};
        end
      end
      default:
        d.st = mmtw_pkg::S_IDLE;
    endcase
    if (stop || timeout)
    begin
      d.st = mmtw_pkg::S_IDLE;
      d.sdaOe = 1'b0;
      d.sclOe = 1'b0;
    end
    else if (start)
    begin
      // repeated start drops any half-done write, counter untouched
      d.st = selected ? mmtw_pkg::S_ADDR : mmtw_pkg::S_IDLE;
      d.bitCnt = '0;
      d.sdaOe = 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.selSync <= 2'b11;
    end
    else
      q <= d;
  end

  mmtw_core u_core (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .reqTgl(q.reqTgl),
    .reqWe(q.reqWe),
    .reqAddr(q.reqAddr),
    .reqData(q.reqData),
    .ackTgl(coreAck),
    .rdData(coreRd),
    .pushValid(pushValid),
    .pushReady(pushReady),
    .pushData(pushData)
  );

  mmtw_fifo #(
    .WIDTH(mmtw_pkg::FIFO_WIDTH),
    .DEPTH(mmtw_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .reset_n(reset_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(wrData)
  );

  default clocking cb @(posedge linkClk);
  endclocking
  default disable iff (!reset_n);

  sequence addrByteDone;
    q.st == mmtw_pkg::S_ADDR && sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS;
  endsequence

  sequence hostAcked;
    q.st == mmtw_pkg::S_RDATA && sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS && q.cont;
  endsequence

  sequence hostNacked;
    q.st == mmtw_pkg::S_RDATA && sclFall && q.bitCnt == mmtw_pkg::BYTE_BITS && !q.cont;
  endsequence

  AST_ADDR_ACK: assert property (
    (addrByteDone and (q.shift[7:1] == mmtw_pkg::DEV_ADDR && selected))
    |=> q.sdaOe && q.st == mmtw_pkg::S_ADDR_ACK)
    else $error("matching address not acknowledged");

  AST_ADDR_MISS: assert property (
    (addrByteDone and (q.shift[7:1] != mmtw_pkg::DEV_ADDR))
    |=> !q.sdaOe && q.st == mmtw_pkg::S_IDLE)
    else $error("foreign address acknowledged");

  AST_DESEL_ADDR: assert property (
    (addrByteDone and !selected) |=> !q.sdaOe)
    else $error("acknowledged while deselected");

  AST_DESEL_START: assert property (
    (start && !selected && !stop) |=> q.st == mmtw_pkg::S_IDLE)
    else $error("start taken while deselected");

  AST_SEL_DEFAULT: assert property (
    $rose(reset_n) |-> q.selSync == 2'b11)
    else $error("select not deselected after reset");

  AST_STRETCH_BOUND: assert property (
    (q.sclOe && q.stretchCnt == STRETCH_LAST) |=> !q.sclOe && q.st == mmtw_pkg::S_IDLE)
    else $error("clock held low too long");

  AST_WRAP: assert property (
    (q.st == mmtw_pkg::S_RWAIT && ackEdge && !stop && !timeout)
    |=> q.addr == mmtw_pkg::nextAddr($past(q.addr)) && q.sdaOe == !$past(coreRd[7]))
    else $error("byte counter did not advance in page");

  AST_RESTART_KEEP: assert property (
    start |=> q.addr == $past(q.addr) ##1 q.st != mmtw_pkg::S_WWAIT)
    else $error("repeated start moved the counter");

  AST_SEQ_READ: assert property (
    hostAcked |=> q.sclOe && q.st == mmtw_pkg::S_RWAIT && q.reqTgl != $past(q.reqTgl))
    else $error("acknowledged read did not continue");

  AST_NACK_END: assert property (
    hostNacked |=> q.st == mmtw_pkg::S_IDLE && !q.sdaOe [*2])
    else $error("read continued after not-acknowledge");
endmodule

// ==== tb/mmtw_host_model.sv ====
// mmtw_host_model: behavioural two-wire bus master that also drives module select
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
module mmtw_host_model #(
  parameter int LOW_NS = 1200,
  parameter int HIGH_NS = 1100,
  parameter int BUF_NS = 20800,
  parameter int SEL_SETUP_NS = 2000000,
  parameter int SEL_HOLD_NS = 10000
) (
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // line pulls and select
  output logic sclPull,
  output logic sdaPull,
  output logic module_select_n
);
  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    module_select_n = 1'b1;
  end
  task automatic selectModule(input logic on);
    if (on)
    begin
      module_select_n = 1'b0;
      #(SEL_SETUP_NS);
    end
    else
    begin
      #(SEL_HOLD_NS);
      module_select_n = 1'b1;
    end
  endtask
  // a stretching slave keeps scl low, so every high phase waits for it
  task automatic releaseScl();
    sclPull = 1'b0;
    while (scl !== 1'b1) #20;
  endtask
  task automatic startCond();
    sdaPull = 1'b0;
    #(LOW_NS);
    releaseScl();
    #(HIGH_NS);
    sdaPull = 1'b1;
    #(HIGH_NS);
    sclPull = 1'b1;
    #100;
  endtask
  task automatic sendBit(input logic b);
    sdaPull = ~b;
    #(LOW_NS);
    releaseScl();
    #(HIGH_NS);
    sclPull = 1'b1;
    #100;
  endtask
  task automatic takeBit(output logic b);
    sdaPull = 1'b0;
    #(LOW_NS);
    releaseScl();
    #(HIGH_NS / 2);
    b = sda;
    #(HIGH_NS / 2);
    sclPull = 1'b1;
    #100;
  endtask
  task automatic writeByte(input logic [7:0] v, output logic acked);
    logic nak;
    for (int i = 7; i >= 0; i--) sendBit(v[i]);
    takeBit(nak);
    acked = ~nak;
  endtask
  task automatic readByte(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) takeBit(v[i]);
    sendBit(last);
  endtask
  task automatic stopCond();
    sdaPull = 1'b1;
    #(LOW_NS);
    releaseScl();
    #(HIGH_NS);
    sdaPull = 1'b0;
    #(BUF_NS);
  endtask
endmodule

// ==== tb/module_mgmt_two_wire_slave_tb_top.sv ====
// module_mgmt_two_wire_slave_tb_top: self-checking bench for the two-wire slave
// assumes pull-ups on both lines, resolved here from every party's pull
`timescale 1ns/1ps
module module_mgmt_two_wire_slave_tb_top;
  localparam int STRETCH = 4000;
  logic ref_clk;
  logic linkClk;
  logic reset_n;
  logic wrReady;
  logic hostScl;
  logic hostSda;
  logic selN;
  logic sclOe;
  logic sdaOe;
  logic wrValid;
  logic [15:0] wrData;
  logic sclOut;
  logic sdaOut;
  // the device side only ever pulls its level while its enable is high
  wire logic scl = ~hostScl & (sclOe ? sclOut : 1'b1);
  wire logic sda = ~hostSda & (sdaOe ? sdaOut : 1'b1);
  int failures;
  int samples_checked;
  logic ok;
  logic [7:0] rd;

  mmtw_slave #(.STRETCH_CYCLES(STRETCH)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .linkClk(linkClk),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .module_select_n(selN), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData)
  );
  // select set-up shortened so the run stays short
  mmtw_host_model #(.SEL_SETUP_NS(20000)) host (
    .scl(scl), .sda(sda), .sclPull(hostScl), .sdaPull(hostSda), .module_select_n(selN)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    linkClk = 1'b0;
    #1.7;
    forever #3 linkClk = ~linkClk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic drainOne(input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    while (wrValid !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({15'h0, wrValid}, 16'h0001);
    check(wrData, exp);
    wrReady = 1'b1;
    @(posedge ref_clk);
    #1;
    wrReady = 1'b0;
  endtask
  task automatic setAddr(input logic [7:0] a);
    host.startCond();
    host.writeByte(8'ha0, ok);
    check({15'h0, ok}, 16'h0001);
    host.writeByte(a, ok);
    check({15'h0, ok}, 16'h0001);
  endtask

  // sixteen words fill the buffer, the seventeenth must stall the bus
  task automatic testFill();
    logic [7:0] a;
    logic [7:0] d;
    host.selectModule(1'b1);
    setAddr(8'h7c);
    for (int i = 0; i < 16; i++)
    begin
      host.writeByte(8'h30 + i[7:0], ok);
      check({15'h0, ok}, 16'h0001);
    end
    fork
      host.writeByte(8'h40, ok);
      begin
        #22000;
        check({15'h0, sclOe}, 16'h0001);
        drainOne({8'h7c, 8'h30});
      end
    join
    check({15'h0, ok}, 16'h0001);
    host.stopCond();
    for (int i = 1; i < 17; i++)
    begin
      a = (8'h7c + i[7:0]) & 8'h7f;
      d = (i == 16) ? 8'h40 : 8'h30 + i[7:0];
      drainOne({a, d});
    end
    $display("testFill done");
  endtask
  // random read across the page end, acked until the last byte
  task automatic testRead();
    setAddr(8'h7e);
    host.startCond();
    host.writeByte(8'ha1, ok);
    check({15'h0, ok}, 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      host.readByte(i == 3, rd);
      check({8'h0, rd}, {8'h0, 8'h32 + i[7:0]});
    end
    host.stopCond();
    $display("testRead done");
  endtask
  // the revision byte takes a write without storing it, then reads back
  task automatic testRev();
    setAddr(mmtw_pkg::REV_ADDR);
    host.writeByte(8'h5a, ok);
    check({15'h0, ok}, 16'h0001);
    check({15'h0, wrValid}, 16'h0000);
    setAddr(mmtw_pkg::REV_ADDR);
    host.startCond();
    host.writeByte(8'ha1, ok);
    check({15'h0, ok}, 16'h0001);
    host.readByte(1'b1, rd);
    check({8'h0, rd}, {8'h0, mmtw_pkg::MAP_REV});
    host.stopCond();
    $display("testRev done");
  endtask
  // foreign address, then own address while deselected
  task automatic testRefuse();
    host.startCond();
    host.writeByte(8'ha2, ok);
    check({15'h0, ok}, 16'h0000);
    host.stopCond();
    host.selectModule(1'b0);
    host.startCond();
    host.writeByte(8'ha0, ok);
    check({15'h0, ok}, 16'h0000);
    host.stopCond();
    check({15'h0, wrValid}, 16'h0000);
    $display("testRefuse done");
  endtask

  initial
  begin
    failures = 0;
    samples_checked = 0;
    wrReady = 1'b0;
    reset_n = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    check({15'h0, wrValid}, 16'h0000);
    repeat (4) @(posedge linkClk);
    testFill();
    testRead();
    testRev();
    testRefuse();
    stop_test();
  end
  initial
  begin
    #990000;
    failures++;
    stop_test();
  end
endmodule
